// [rtl/ebr_defs.svh]
// Geometry and limit constants of the embedded RAM block.
// Included by the package and by each design file; definitions only.
`ifndef EBR_DEFS_SVH
`define EBR_DEFS_SVH

`define EBR_SM_DATA  20'h00200
`define EBR_MD_DATA  20'h01000
`define EBR_LG_DATA  20'h80000
`define EBR_SM_NAT   8'h12
`define EBR_MD_NAT   8'h24
`define EBR_LG_NAT   8'h90
`define EBR_SM_MAXB  8'h12
`define EBR_MD_MAXB  8'h24
`define EBR_LG_MINB  8'h08
`define EBR_MAXW     144
`define EBR_AW       16
`define EBR_BEW      16
`define EBR_PW       17
`define EBR_LDAW     7
`define EBR_LDDW     36
`define EBR_CODE_MAX 4'hC
`define EBR_MODE_MAX 3'h5

`endif

// [rtl/ebr_pkg.sv]
// Types shared by the embedded RAM block modules.
// Assumes ebr_defs.svh is on the include path.
package ebr_pkg;
`include "ebr_defs.svh"

  typedef enum logic [1:0] {
    EBR_SMALL  = 2'h0,
    EBR_MEDIUM = 2'h1,
    EBR_LARGE  = 2'h2
  } ebr_kind_t;

  typedef enum logic [2:0] {
    EBR_M_SP    = 3'h0,
    EBR_M_SDP   = 3'h1,
    EBR_M_TDP   = 3'h2,
    EBR_M_TWOSP = 3'h3,
    EBR_M_ROM   = 3'h4,
    EBR_M_FIFO  = 3'h5
  } ebr_mode_t;

  typedef enum logic [3:0] {
    EBR_W1 = 4'h0, EBR_W2 = 4'h1, EBR_W4 = 4'h2, EBR_W8 = 4'h3,
    EBR_W9 = 4'h4, EBR_W16 = 4'h5, EBR_W18 = 4'h6, EBR_W32 = 4'h7,
    EBR_W36 = 4'h8, EBR_W64 = 4'h9, EBR_W72 = 4'hA, EBR_W128 = 4'hB,
    EBR_W144 = 4'hC
  } ebr_wsel_t;

  typedef enum logic {
    EBR_S_LOAD = 1'b0,
    EBR_S_RUN  = 1'b1
  } ebr_st_t;

  typedef struct packed {
    logic                   we;
    logic                   re;
    logic [`EBR_AW-1:0]     addr;
    logic [`EBR_MAXW-1:0]   data;
    logic [`EBR_BEW-1:0]    be;
    logic [`EBR_MAXW-1:0]   rd;
    logic [`EBR_MAXW-1:0]   q;
  } ebr_port_t;

  typedef struct packed {
    ebr_st_t                st;
    logic [`EBR_PW-1:0]     wp;
    logic [`EBR_PW-1:0]     rp;
    logic [`EBR_PW:0]       cnt;
  } ebr_core_t;

endpackage

// [rtl/ebr_wdec.sv]
// Port width decoder: bits per word, parity form, word count, legality.
// Pure combinational; fed by static configuration inputs.
`include "ebr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ebr_wdec
  import ebr_pkg::*;
(
  input  wire ebr_kind_t         i_kind,
  input  wire logic [3:0]        i_wsel,
  output logic [7:0]             o_bits,
  output logic                   o_par,
  output logic [`EBR_PW-1:0]     o_words,
  output logic                   o_ok
);
  logic [3:0]  ps;
  logic [19:0] data;

  always_comb
  begin
    unique case (i_wsel)
      EBR_W1:   ps = 4'h0;
      EBR_W2:   ps = 4'h1;
      EBR_W4:   ps = 4'h2;
      EBR_W8:   ps = 4'h3;
      EBR_W9:   ps = 4'h8;
      EBR_W16:  ps = 4'h4;
      EBR_W18:  ps = 4'h9;
      EBR_W32:  ps = 4'h5;
      EBR_W36:  ps = 4'hA;
      EBR_W64:  ps = 4'h6;
      EBR_W72:  ps = 4'hB;
      EBR_W128: ps = 4'h7;
      EBR_W144: ps = 4'hC;
      default:  ps = 4'h0;
    endcase
    o_par = ps[3];
    o_bits = o_par ? (8'h09 << ps[2:0]) : (8'h01 << ps[2:0]);
    unique case (i_kind)
      EBR_SMALL:  data = `EBR_SM_DATA;
      EBR_MEDIUM: data = `EBR_MD_DATA;
      default:    data = `EBR_LG_DATA;
    endcase
    // Parity widths are nine bits per byte, so words follow the byte count
    o_words = `EBR_PW'(data >> (o_par ? ps[2:0] + 3'h3 : ps[2:0]));
    unique case (i_kind)
      EBR_SMALL:  o_ok = o_bits <= `EBR_SM_MAXB;
      EBR_MEDIUM: o_ok = o_bits <= `EBR_MD_MAXB;
      default:    o_ok = o_bits >= `EBR_LG_MINB;
    endcase
    if (i_wsel > `EBR_CODE_MAX)
      o_ok = 1'b0;
  end

endmodule
`default_nettype wire

// [rtl/ebr_port.sv]
// One memory port: input registers with clear, read latch, output register.
// Driven by fabric logic on i_mclk; memory access is done by the parent.
`include "ebr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ebr_port
  import ebr_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  input  wire logic                  i_we,
  input  wire logic                  i_re,
  input  wire logic [`EBR_AW-1:0]    i_addr,
  input  wire logic [`EBR_MAXW-1:0]  i_data,
  input  wire logic [`EBR_BEW-1:0]   i_be,
  input  wire logic                  i_inclr,
  input  wire logic                  i_inclr_ok,
  input  wire logic                  i_outclr,
  input  wire logic                  i_bypass,
  input  wire logic                  i_fire,
  input  wire logic [`EBR_MAXW-1:0]  i_rd_word,
  output logic                       o_we,
  output logic                       o_re,
  output logic [`EBR_AW-1:0]         o_addr,
  output logic [`EBR_MAXW-1:0]       o_data,
  output logic [`EBR_BEW-1:0]        o_be,
  output logic [`EBR_MAXW-1:0]       o_q
);
  ebr_port_t s_ff;
  ebr_port_t nxt_s;
  logic      in_clr;

  assign in_clr = i_inclr & i_inclr_ok;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.we = in_clr ? 1'b0 : i_we;
    nxt_s.re = in_clr ? 1'b0 : i_re;
    nxt_s.addr = in_clr ? '0 : i_addr;
    nxt_s.data = in_clr ? '0 : i_data;
    nxt_s.be = in_clr ? '0 : i_be;
    if (i_fire)
      nxt_s.rd = i_rd_word;
    nxt_s.q = i_outclr ? '0 : s_ff.rd;
    if (i_reset)
      nxt_s = '0;
  end

  always_ff @(posedge i_mclk)
    s_ff <= nxt_s;

  // Clear masks the held values at once; the array sees it at the next edge
  assign o_we = in_clr ? 1'b0 : s_ff.we;
  assign o_re = in_clr ? 1'b0 : s_ff.re;
  assign o_addr = in_clr ? '0 : s_ff.addr;
  assign o_data = in_clr ? '0 : s_ff.data;
  assign o_be = in_clr ? '0 : s_ff.be;
  assign o_q = i_bypass ? s_ff.rd : (i_outclr ? '0 : s_ff.q);

endmodule
`default_nettype wire

// [rtl/ebr_ram_block.sv]
// Embedded synchronous RAM block: small, medium or large geometry.
// Both ports run on i_mclk; fabric drives static mode and width selects.
`include "ebr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ebr_ram_block
  import ebr_pkg::*;
#(
  parameter ebr_kind_t KIND = EBR_MEDIUM
)
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  input  wire logic [2:0]            i_mode,
  input  wire logic [3:0]            i_a_wsel,
  input  wire logic [3:0]            i_b_wsel,
  input  wire logic                  i_bypass,
  input  wire logic                  i_flow,
  input  wire logic                  i_a_we,
  input  wire logic                  i_a_re,
  input  wire logic [`EBR_AW-1:0]    i_a_addr,
  input  wire logic [`EBR_MAXW-1:0]  i_a_data,
  input  wire logic [`EBR_BEW-1:0]   i_a_be,
  input  wire logic                  i_a_inclr,
  input  wire logic                  i_a_outclr,
  input  wire logic                  i_b_we,
  input  wire logic                  i_b_re,
  input  wire logic [`EBR_AW-1:0]    i_b_addr,
  input  wire logic [`EBR_MAXW-1:0]  i_b_data,
  input  wire logic [`EBR_BEW-1:0]   i_b_be,
  input  wire logic                  i_b_inclr,
  input  wire logic                  i_b_outclr,
  input  wire logic                  i_ld_we,
  input  wire logic [`EBR_LDAW-1:0]  i_ld_addr,
  input  wire logic [`EBR_LDDW-1:0]  i_ld_data,
  input  wire logic                  i_ld_done,
  output logic [`EBR_MAXW-1:0]       o_a_q,
  output logic [`EBR_MAXW-1:0]       o_b_q,
  output logic                       o_full,
  output logic                       o_empty,
  output logic                       o_cfg_err,
  output logic                       o_loading
);
  localparam int DATAB = (KIND == EBR_SMALL) ? `EBR_SM_DATA :
                         (KIND == EBR_MEDIUM) ? `EBR_MD_DATA : `EBR_LG_DATA;
  localparam int TOTB = DATAB / 8 * 9;
  localparam int NAT = (KIND == EBR_SMALL) ? `EBR_SM_NAT :
                       (KIND == EBR_MEDIUM) ? `EBR_MD_NAT : `EBR_LG_NAT;
  localparam int LDW = TOTB / NAT;
  localparam ebr_st_t ST0 = (KIND == EBR_LARGE) ? EBR_S_RUN : EBR_S_LOAD;

  logic                  mem [0:TOTB-1];
  ebr_core_t             s_ff;
  ebr_core_t             nxt_s;

  logic [7:0]            a_bits;
  logic [7:0]            b_bits;
  logic                  a_par;
  logic                  b_par;
  logic                  a_ok;
  logic                  b_ok;
  logic [`EBR_PW-1:0]    a_words;
  logic [`EBR_PW-1:0]    b_words;
  logic                  a_we;
  logic                  a_re;
  logic                  b_we;
  logic                  b_re;
  logic [`EBR_AW-1:0]    a_addr;
  logic [`EBR_AW-1:0]    b_addr;
  logic [`EBR_AW-1:0]    b_ad;
  logic                  b_en;
  logic [`EBR_BEW-1:0]   a_be;
  logic [`EBR_BEW-1:0]   b_be;
  logic [`EBR_MAXW-1:0]  a_data;
  logic [`EBR_MAXW-1:0]  b_data;
  logic [`EBR_MAXW-1:0]  a_rdw;
  logic [`EBR_MAXW-1:0]  b_rdw;
  logic [`EBR_PW-1:0]    a_wa;
  logic [`EBR_PW-1:0]    b_wa;
  logic [`EBR_PW-1:0]    a_lim;
  logic [`EBR_PW-1:0]    b_lim;
  logic                  a_fire;
  logic                  b_fire;
  logic                  wr_a;
  logic                  wr_b;
  logic                  rd_a;
  logic                  rd_b;
  logic                  cfg_err;
  logic                  run;
  logic                  single;
  logic                  coll;
  logic                  full;
  logic                  empty;
  logic                  ld_fire;
  int                    la;
  int                    lb;

  // Data-only widths skip the ninth bit of each byte
  function automatic int phys(input int l, input logic par);
    phys = par ? l : (l / 8) * 9 + (l % 8);
  endfunction

  function automatic logic lane_on(input logic [`EBR_BEW-1:0] be, input int i,
                                   input logic par);
    lane_on = (KIND == EBR_SMALL) | be[par ? i / 9 : i / 8];
  endfunction

  function automatic logic [`EBR_MAXW-1:0] rd_word(input int l, input logic [7:0] bits,
                                                   input logic par);
    rd_word = '0;
    for (int i = 0; i < `EBR_MAXW; i++)
      if (i < int'(bits))
        rd_word[i] = mem[phys(l + i, par)];
  endfunction

  ebr_wdec u_wdec_a (
    .i_kind  (KIND),
    .i_wsel  (i_a_wsel),
    .o_bits  (a_bits),
    .o_par   (a_par),
    .o_words (a_words),
    .o_ok    (a_ok)
  );

  ebr_wdec u_wdec_b (
    .i_kind  (KIND),
    .i_wsel  (i_b_wsel),
    .o_bits  (b_bits),
    .o_par   (b_par),
    .o_words (b_words),
    .o_ok    (b_ok)
  );

  ebr_port u_port_a (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_we       (i_a_we),
    .i_re       (i_a_re),
    .i_addr     (i_a_addr),
    .i_data     (i_a_data),
    .i_be       (i_a_be),
    .i_inclr    (i_a_inclr),
    .i_inclr_ok (KIND != EBR_LARGE),
    .i_outclr   (i_a_outclr),
    .i_bypass   (i_bypass),
    .i_fire     (a_fire),
    .i_rd_word  (a_rdw),
    .o_we       (a_we),
    .o_re       (a_re),
    .o_addr     (a_addr),
    .o_data     (a_data),
    .o_be       (a_be),
    .o_q        (o_a_q)
  );

  ebr_port u_port_b (
    .i_mclk     (i_mclk),
    .i_reset    (i_reset),
    .i_we       (i_b_we),
    .i_re       (i_b_re),
    .i_addr     (i_b_addr),
    .i_data     (i_b_data),
    .i_be       (i_b_be),
    .i_inclr    (i_b_inclr),
    .i_inclr_ok (KIND != EBR_LARGE),
    .i_outclr   (i_b_outclr),
    .i_bypass   (i_bypass),
    .i_fire     (b_fire),
    .i_rd_word  (b_rdw),
    .o_we       (b_we),
    .o_re       (b_re),
    .o_addr     (b_addr),
    .o_data     (b_data),
    .o_be       (b_be),
    .o_q        (o_b_q)
  );

  always_comb
  begin
    cfg_err = (i_mode > `EBR_MODE_MAX) | !a_ok | ((i_mode != EBR_M_SP) & !b_ok)
            | ((i_mode == EBR_M_TDP) & (KIND == EBR_SMALL))
            | ((i_mode == EBR_M_TWOSP) & (KIND != EBR_MEDIUM))
            | ((i_mode == EBR_M_ROM) & (KIND == EBR_LARGE))
            | (i_flow & ((KIND == EBR_LARGE) | (i_mode != EBR_M_SDP) | !i_bypass))
            | ((i_mode == EBR_M_FIFO) & (i_a_wsel != i_b_wsel))
            | (((i_mode == EBR_M_SDP) | (i_mode == EBR_M_TDP)) & (a_par != b_par));
    run = (s_ff.st == EBR_S_RUN) & !cfg_err;
    single = (i_mode == EBR_M_SP) | (i_mode == EBR_M_TWOSP);
    full = (i_mode == EBR_M_FIFO) & (s_ff.cnt == {1'b0, a_words});
    empty = s_ff.cnt == '0;
    // Flow-through takes the raw read request, one cycle ahead of the registered request
    b_ad = i_flow ? i_b_addr : b_addr;
    b_en = i_flow ? i_b_re : b_re;
    a_lim = (i_mode == EBR_M_TWOSP) ? (a_words >> 1) : a_words;
    b_lim = (i_mode == EBR_M_TWOSP) ? (b_words >> 1) : b_words;
    if (i_mode == EBR_M_FIFO)
    begin
      a_wa = s_ff.wp;
      b_wa = s_ff.rp;
    end
    else
    begin
      a_wa = {1'b0, a_addr};
      b_wa = (i_mode == EBR_M_TWOSP) ? {1'b0, b_ad} + (b_words >> 1) : {1'b0, b_ad};
    end
    la = int'(a_wa) * int'(a_bits);
    lb = int'(b_wa) * int'(b_bits);
    wr_a = run & a_we & (i_mode != EBR_M_ROM) & ({1'b0, a_addr} < a_lim)
         & !full;
    rd_a = run & a_re & ({1'b0, a_addr} < a_lim) & !(single & a_we)
         & ((i_mode == EBR_M_SP) | (i_mode == EBR_M_TDP)
         | (i_mode == EBR_M_TWOSP) | (i_mode == EBR_M_ROM));
    if (i_mode == EBR_M_FIFO)
      wr_a = run & a_we & !full;
    wr_b = run & b_we & ({1'b0, b_ad} < b_lim)
         & ((i_mode == EBR_M_TDP) | (i_mode == EBR_M_TWOSP));
    rd_b = run & b_en & (i_mode != EBR_M_SP) & ({1'b0, b_ad} < b_lim)
         & !((i_mode == EBR_M_TWOSP) & b_we);
    if (i_mode == EBR_M_FIFO)
      rd_b = run & b_en & !empty;
    coll = wr_a & rd_b & ((i_mode == EBR_M_SDP) | (i_mode == EBR_M_TDP))
         & (la < lb + int'(b_bits)) & (lb < la + int'(a_bits));
    ld_fire = (s_ff.st == EBR_S_LOAD) & i_ld_we & (int'(i_ld_addr) < LDW)
            & (KIND != EBR_LARGE);
  end

  // A single-port write also refreshes that port's read path with the new word
  always_comb
  begin
    a_fire = rd_a | (single & wr_a);
    b_fire = rd_b | ((i_mode == EBR_M_TWOSP) & wr_b);
    if (single & wr_a)
      a_rdw = a_data & ~({`EBR_MAXW{1'b1}} << a_bits);
    else if (rd_a)
      a_rdw = rd_word(la, a_bits, a_par);
    else
      a_rdw = '0;
    if ((i_mode == EBR_M_TWOSP) & wr_b)
      b_rdw = b_data & ~({`EBR_MAXW{1'b1}} << b_bits);
    else if (coll & (KIND == EBR_LARGE))
      b_rdw = '1;
    else if (rd_b)
      b_rdw = rd_word(lb, b_bits, b_par);
    else
      b_rdw = '0;
  end

  always_comb
  begin
    nxt_s = s_ff;
    if (i_mode != EBR_M_FIFO)
    begin
      nxt_s.wp = '0;
      nxt_s.rp = '0;
      nxt_s.cnt = '0;
    end
    else
    begin
      if (wr_a)
        nxt_s.wp = (s_ff.wp + 1'b1 == a_words) ? '0 : s_ff.wp + 1'b1;
      if (rd_b)
        nxt_s.rp = (s_ff.rp + 1'b1 == a_words) ? '0 : s_ff.rp + 1'b1;
      nxt_s.cnt = s_ff.cnt + {{`EBR_PW{1'b0}}, wr_a} - {{`EBR_PW{1'b0}}, rd_b};
    end
    if ((s_ff.st == EBR_S_LOAD) & i_ld_done)
      nxt_s.st = EBR_S_RUN;
    if (i_reset)
    begin
      nxt_s = '0;
      nxt_s.st = ST0;
    end
  end

  always_ff @(posedge i_mclk)
    s_ff <= nxt_s;

  // Port writes use the registered request, one edge after capture; image loads use the raw load inputs
  always_ff @(posedge i_mclk)
  begin
    if (ld_fire)
    begin
      for (int i = 0; i < `EBR_LDDW; i++)
        if (i < NAT)
          mem[int'(i_ld_addr) * NAT + i] <= i_ld_data[i];
    end
    if (wr_a)
    begin
      for (int i = 0; i < `EBR_MAXW; i++)
        if (i < int'(a_bits) && lane_on(a_be, i, a_par))
          mem[phys(la + i, a_par)] <= a_data[i];
    end
    if (wr_b)
    begin
      for (int i = 0; i < `EBR_MAXW; i++)
        if (i < int'(b_bits) && lane_on(b_be, i, b_par))
          mem[phys(lb + i, b_par)] <= b_data[i];
    end
  end

  assign o_full = full;
  assign o_empty = empty;
  assign o_cfg_err = cfg_err;
  assign o_loading = s_ff.st == EBR_S_LOAD;

endmodule
`default_nettype wire

// [testbench/ebr_ram_block_monitor.sv]
// Concurrent checks on the top ports of the embedded RAM block.
// Assumes ebr_pkg is compiled first; attached to every instance by bind.
`include "ebr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ebr_ram_block_monitor
  import ebr_pkg::*;
#(
  parameter ebr_kind_t KIND = EBR_MEDIUM
)
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  input  wire logic [2:0]            i_mode,
  input  wire logic                  i_bypass,
  input  wire logic                  i_a_we,
  input  wire logic                  i_a_re,
  input  wire logic                  i_a_outclr,
  input  wire logic                  i_b_outclr,
  input  wire logic                  i_ld_done,
  input  wire logic [`EBR_MAXW-1:0]  o_a_q,
  input  wire logic [`EBR_MAXW-1:0]  o_b_q,
  input  wire logic                  o_full,
  input  wire logic                  o_empty,
  input  wire logic                  o_cfg_err,
  input  wire logic                  o_loading
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  chk_outclr_a_now: assert property (
    i_a_outclr && !i_bypass |-> o_a_q == '0) else $error("port A clear not immediate");
  chk_outclr_b_now: assert property (
    i_b_outclr && !i_bypass |-> o_b_q == '0) else $error("port B clear not immediate");
  chk_reset_out_zero: assert property (
    $fell(i_reset) |-> o_a_q == '0 && o_b_q == '0) else $error("outputs not cleared");
  chk_reset_load_flag: assert property (
    $fell(i_reset) |-> o_loading == (KIND != EBR_LARGE)) else $error("load flag wrong");
  chk_reset_fifo_flags: assert property (
    $fell(i_reset) |-> o_empty && !o_full) else $error("fifo flags wrong after reset");
  chk_bad_mode_err: assert property (
    i_mode > 3'h5 |-> o_cfg_err) else $error("illegal mode not flagged");
  chk_load_exit: assert property (
    o_loading && i_ld_done |=> !o_loading) else $error("load did not finish");
  chk_load_stay: assert property (
    o_loading && !i_ld_done |=> o_loading) else $error("load left early");
  // A change shows one edge after the latch or output register loads
  chk_hold_a_quiet: assert property (
    $past(!i_a_we && !i_a_re, 2) && $past(!i_a_we && !i_a_re, 3) && !i_a_outclr
    && $past(!i_a_outclr) && $past(!i_a_outclr, 2) && $stable(i_bypass)
    && $stable(i_mode) |-> $stable(o_a_q))
    else $error("port A output moved without a request");
endmodule

bind ebr_ram_block ebr_ram_block_monitor #(.KIND(KIND)) mon_u (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_mode(i_mode), .i_bypass(i_bypass),
  .i_a_we(i_a_we), .i_a_re(i_a_re), .i_a_outclr(i_a_outclr), .i_b_outclr(i_b_outclr),
  .i_ld_done(i_ld_done), .o_a_q(o_a_q), .o_b_q(o_b_q), .o_full(o_full),
  .o_empty(o_empty), .o_cfg_err(o_cfg_err), .o_loading(o_loading));

`default_nettype wire

// [testbench/ebr_fab_model.sv]
// Fabric-side image loader: writes all native words once, then stops.
// Assumes the block waits in its load state; drives on falling edges.
`include "ebr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ebr_fab_model
  import ebr_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_start,
  output logic                       o_ld_we,
  output logic [`EBR_LDAW-1:0]       o_ld_addr,
  output logic [`EBR_LDDW-1:0]       o_ld_data,
  output logic                       o_ld_done
);
  int k;

  initial
  begin
    o_ld_we = 1'b0;
    o_ld_addr = 7'h00;
    o_ld_data = 36'h0;
    o_ld_done = 1'b0;
    forever
    begin
      @(negedge i_mclk);
      if (i_start)
      begin
        for (k = 0; k < 128; k++)
        begin
          o_ld_we <= 1'b1;
          o_ld_addr <= 7'(k);
          o_ld_data <= {~7'(k), 22'h0, 7'(k)};
          @(negedge i_mclk);
        end
        o_ld_we <= 1'b0;
        o_ld_done <= 1'b1;
        @(negedge i_mclk);
        o_ld_done <= 1'b0;
      end
      else
      begin
        // Released lines must not look like a held word
        o_ld_data <= ~o_ld_data;
        o_ld_addr <= ~o_ld_addr;
      end
    end
  end
endmodule

`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for a medium embedded RAM block.
// Assumes rtl package, design and the two bench modules are compiled first.
`include "ebr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end

module tb;
  import ebr_pkg::*;
  logic i_mclk, i_reset, i_bypass, i_a_we, i_a_re, i_b_we, i_b_re, i_a_inclr, i_a_outclr;
  logic start, ld_we, ld_done, o_full, o_empty, o_cfg_err, o_loading, i_flow;
  logic [2:0] i_mode;
  logic [3:0] a_wsel, b_wsel;
  logic [15:0] i_a_addr, i_b_addr, i_a_be;
  logic [143:0] i_a_data, i_b_data, o_a_q, o_b_q;
  logic [6:0] ld_addr;
  logic [35:0] ld_data;
  int n_mismatch = 0;
  int n_compared = 0;

  ebr_ram_block #(.KIND(EBR_MEDIUM)) dut_u (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_mode(i_mode), .i_a_wsel(a_wsel),
    .i_b_wsel(b_wsel), .i_bypass(i_bypass), .i_flow(i_flow), .i_a_we(i_a_we),
    .i_a_re(i_a_re), .i_a_addr(i_a_addr), .i_a_data(i_a_data), .i_a_be(i_a_be),
    .i_a_inclr(i_a_inclr), .i_a_outclr(i_a_outclr), .i_b_we(i_b_we), .i_b_re(i_b_re),
    .i_b_addr(i_b_addr), .i_b_data(i_b_data), .i_b_be(16'hFFFF), .i_b_inclr(1'b0),
    .i_b_outclr(1'b0), .i_ld_we(ld_we), .i_ld_addr(ld_addr), .i_ld_data(ld_data),
    .i_ld_done(ld_done), .o_a_q(o_a_q), .o_b_q(o_b_q), .o_full(o_full),
    .o_empty(o_empty), .o_cfg_err(o_cfg_err), .o_loading(o_loading));

  ebr_fab_model fab_u (.i_mclk(i_mclk), .i_start(start), .o_ld_we(ld_we),
    .o_ld_addr(ld_addr), .o_ld_data(ld_data), .o_ld_done(ld_done));

  function automatic logic [143:0] img(input logic [6:0] a);
    return {108'h0, ~a, 22'h0, a};
  endfunction

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input logic awe, are, input logic [15:0] aa, input logic [143:0] ad,
                     input logic bwe, bre, input logic [15:0] ba, input logic [143:0] bd);
    @(negedge i_mclk);
    {i_a_we, i_a_re, i_a_addr, i_a_data} = {awe, are, aa, ad};
    {i_b_we, i_b_re, i_b_addr, i_b_data} = {bwe, bre, ba, bd};
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(0, 0, 0, 0, 0, 0, 0, 0);
  endtask

  task automatic t_load();
    int k;
    // Held over two falling edges so the loader sees it whatever the process order
    start = 1'b1;
    repeat (2) @(negedge i_mclk);
    start = 1'b0;
    for (k = 0; k < 400 && o_loading !== 1'b0; k++)
      @(negedge i_mclk);
    if (k == 400)
    begin
      n_mismatch++;
      end_sim();
    end
    cyc(0, 1, 5, 0, 0, 0, 0, 0);
    cyc(0, 1, 127, 0, 0, 0, 0, 0);
    idle(2);
    `CHK("image word 5", img(5), o_a_q)
    idle(1);
    `CHK("image word 127", img(127), o_a_q)
    $display("test load done");
  endtask

  task automatic t_single();
    cyc(1, 0, 9, 144'h9_1234_5678, 0, 0, 0, 0);
    idle(2);
    `CHK("registered write early", img(127), o_a_q)
    idle(1);
    `CHK("registered write", 144'h9_1234_5678, o_a_q)
    i_bypass = 1'b1;
    cyc(1, 0, 10, 144'h5_A5A5_0F0F, 0, 0, 0, 0);
    idle(2);
    `CHK("bypassed write", 144'h5_A5A5_0F0F, o_a_q)
    i_bypass = 1'b0;
    $display("test single port done");
  endtask

  task automatic t_clear();
    cyc(0, 1, 9, 0, 0, 0, 0, 0);
    idle(3);
    i_a_outclr = 1'b1;
    #1;
    `CHK("output clear", 144'h0, o_a_q)
    cyc(1, 0, 9, 144'hC_CCCC_3333, 0, 0, 0, 0);
    i_a_outclr = 1'b0;
    idle(1);
    // Clear lands after capture: the held write must die before the array edge
    i_a_inclr = 1'b1;
    idle(1);
    i_a_inclr = 1'b0;
    cyc(0, 1, 9, 0, 0, 0, 0, 0);
    idle(3);
    `CHK("write lost to clear", 144'h9_1234_5678, o_a_q)
    $display("test clears done");
  endtask

  task automatic t_bytes();
    i_a_be = 16'h0001;
    cyc(1, 0, 3, {144{1'b1}}, 0, 0, 0, 0);
    idle(1);
    i_a_be = 16'hFFFF;
    cyc(0, 1, 3, 0, 0, 0, 0, 0);
    idle(3);
    `CHK("byte enable", img(3) | 144'h1FF, o_a_q)
    $display("test byte enables done");
  endtask

  task automatic t_dual();
    int k;
    logic [15:0] pat;
    pat = 16'hA5C3;
    i_mode = 3'h1;
    a_wsel = 4'h0;
    b_wsel = 4'h5;
    for (k = 0; k < 16; k++)
      cyc(1, 0, 16'(k), {143'h0, pat[k]}, 0, 0, 0, 0);
    cyc(0, 0, 0, 0, 0, 1, 0, 0);
    idle(3);
    `CHK("mixed width read", {128'h0, pat}, o_b_q)
    cyc(1, 0, 0, 0, 0, 1, 0, 0);
    idle(3);
    `CHK("collision old data", {128'h0, pat}, o_b_q)
    cyc(0, 0, 0, 0, 0, 1, 0, 0);
    idle(3);
    `CHK("write after collision", {128'h0, pat & 16'hFFFE}, o_b_q)
    {i_flow, i_bypass} = 2'b11;
    cyc(1, 0, 0, 144'h1, 0, 0, 0, 0);
    idle(1);
    cyc(0, 0, 0, 0, 0, 1, 0, 0);
    idle(1);
    `CHK("flow-through read", {128'h0, pat}, o_b_q)
    {i_flow, i_bypass} = 2'b00;
    i_mode = 3'h2;
    a_wsel = 4'h8;
    b_wsel = 4'h8;
    cyc(1, 0, 20, 144'h1_1111_2222, 1, 0, 21, 144'h7_7777_8888);
    cyc(0, 1, 21, 0, 0, 1, 20, 0);
    idle(3);
    `CHK("port A reads B word", 144'h7_7777_8888, o_a_q)
    `CHK("port B reads A word", 144'h1_1111_2222, o_b_q)
    $display("test dual port done");
  endtask

  task automatic t_fifo();
    int k;
    i_mode = 3'h5;
    for (k = 0; k < 128; k++)
      cyc(1, 0, 0, 144'(k + 1), 0, 0, 0, 0);
    // One push past full must be dropped, not wrap onto the first word
    cyc(1, 0, 0, 144'hF_FFFF_FFFF, 0, 0, 0, 0);
    idle(1);
    `CHK("fifo full", 1'b1, o_full)
    cyc(0, 0, 0, 0, 0, 1, 0, 0);
    idle(3);
    `CHK("fifo first word", 144'h1, o_b_q)
    `CHK("fifo full after pop", 1'b0, o_full)
    `CHK("fifo empty after pop", 1'b0, o_empty)
    $display("test fifo done");
  endtask

  task automatic t_config();
    i_mode = 3'h6;
    #1;
    `CHK("illegal mode", 1'b1, o_cfg_err)
    i_mode = 3'h3;
    #1;
    `CHK("split mode", 1'b0, o_cfg_err)
    $display("test config done");
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  initial
  begin
    {i_a_we, i_a_re, i_b_we, i_b_re, i_a_inclr, i_a_outclr, i_bypass, start} = 8'h00;
    {i_a_addr, i_b_addr, i_a_data, i_b_data} = '0;
    i_a_be = 16'hFFFF;
    i_flow = 1'b0;
    i_mode = 3'h0;
    a_wsel = 4'h8;
    b_wsel = 4'h8;
    i_reset = 1'b1;
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk);
    i_reset = 1'b0;
    `CHK("a_q at reset", 144'h0, o_a_q)
    `CHK("b_q at reset", 144'h0, o_b_q)
    `CHK("loading at reset", 1'b1, o_loading)
    `CHK("empty at reset", 1'b1, o_empty)
    t_load();
    t_single();
    t_clear();
    t_bytes();
    t_dual();
    t_fifo();
    t_config();
    end_sim();
  end
endmodule

`default_nettype wire
